// >>> verilog/dpso_override.sv
// main pll state machine with software state and input overrides
//
// Our own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module dpso_override
  import dpso_pkg::*;
#(
  parameter int NUM_IN = DPSO_NUM_IN,
  parameter int PRIO_W = DPSO_PRIO_W
) (
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic [DPSO_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [DPSO_DATA_W-1:0] avs_writedata,
  input  wire logic [DPSO_LANES-1:0]  avs_byteenable,
  output logic      [DPSO_DATA_W-1:0] avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [NUM_IN-1:0]      input_ok,
  input  wire dpso_monitor_type       monitor,
  output logic      [2:0]             pll_state_code,
  output logic      [3:0]             sel_code,
  output logic                        sel_valid
);

  if (NUM_IN != DPSO_NUM_IN) begin : g_chk_in
    $error("input count must match the forced input code table");
  end
  if (PRIO_W != DPSO_PRIO_W) begin : g_chk_prio
    $error("priority width must match the priority register layout");
  end


  // bus handshake


  logic fetch;
  logic commit;

  dpso_avs_port u_port (
    .clk_sys         (clk_sys),
    .arst_n          (arst_n),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_waitrequest (avs_waitrequest),
    .fetch           (fetch),
    .commit          (commit)
  );


  // software registers


  logic [2:0]               state_override_field;
  logic [3:0]               forced_input_field;
  logic [NUM_IN*PRIO_W-1:0] input_prio;
  logic                     forced_lost;

  logic [DPSO_DATA_W-1:0]   lane_mask;
  logic [DPSO_DATA_W-1:0]   wmerge_ovr;
  logic [DPSO_DATA_W-1:0]   wmerge_ref;
  logic [DPSO_DATA_W-1:0]   wmerge_prio;
  logic                     wr_ovr;
  logic                     wr_ref;
  logic                     wr_prio;
  logic                     wr_status;
  dpso_status_type          wr_status_bits;

  assign lane_mask = dpso_lane_mask(avs_byteenable);
  assign wr_ovr    = commit & avs_write & (avs_address == DPSO_OFS_STATE_OVR);
  assign wr_ref    = commit & avs_write & (avs_address == DPSO_OFS_FORCED);
  assign wr_prio   = commit & avs_write & (avs_address == DPSO_OFS_PRIO);
  assign wr_status = commit & avs_write & (avs_address == DPSO_OFS_STATUS);

  // lanes left out by byteenable keep their old contents
  assign wmerge_ovr  = (DPSO_DATA_W'(state_override_field) & ~lane_mask) |
                       (avs_writedata & lane_mask);
  assign wmerge_ref  = (DPSO_DATA_W'(forced_input_field) & ~lane_mask) |
                       (avs_writedata & lane_mask);
  assign wmerge_prio = (DPSO_DATA_W'(input_prio) & ~lane_mask) |
                       (avs_writedata & lane_mask);
  assign wr_status_bits = dpso_status_type'(avs_writedata & lane_mask);

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state_override_field <= DPSO_RST_STATE_OVR;
    end else if (wr_ovr) begin
      // upper bits are not stored and read back as zero
      state_override_field <= wmerge_ovr[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      forced_input_field <= DPSO_RST_FORCED;
    end else if (wr_ref) begin
      forced_input_field <= wmerge_ref[3:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      input_prio <= (NUM_IN*PRIO_W)'(DPSO_RST_PRIO);
    end else if (wr_prio) begin
      input_prio <= wmerge_prio[NUM_IN*PRIO_W-1:0];
    end
  end


  // override decode


  logic                state_forced;
  dpso_state_type      forced_state;
  logic [NUM_IN-1:0]   forced_hot;
  logic                ref_forced;

  assign state_forced = dpso_override_on(state_override_field);
  assign forced_state = dpso_code_to_state(state_override_field);
  assign forced_hot   = dpso_ref_hot(forced_input_field);
  assign ref_forced   = |forced_hot;


  // input choice


  logic [NUM_IN-1:0] pick_hot;
  logic              pick_valid;
  logic [NUM_IN-1:0] sel_hot;

  dpso_ref_select #(
    .NUM_IN (NUM_IN),
    .PRIO_W (PRIO_W)
  ) u_select (
    .input_ok   (input_ok),
    .prio       (input_prio),
    .forced_hot (forced_hot),
    .sel_hot    (pick_hot),
    .sel_valid  (pick_valid)
  );

  // registered so the state machine sees one settled choice per cycle
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_hot   <= '0;
      sel_valid <= 1'b0;
      sel_code  <= DPSO_REF_AUTO;
    end else begin
      sel_hot   <= pick_hot;
      sel_valid <= pick_valid;
      sel_code  <= dpso_hot_to_code(pick_hot);
    end
  end


  // reference health as the state machine sees it


  logic ref_ok;
  logic ref_really_ok;
  logic lose_ref;

  assign ref_really_ok = |(sel_hot & input_ok);
  // a forced input is trusted whatever its monitor says
  assign ref_ok        = sel_valid & (ref_forced | ref_really_ok);
  // never drop to holdover on a forced input
  assign lose_ref      = ~ref_ok & ~ref_forced;


  // main pll state machine


  dpso_state_type state;
  dpso_state_type next_state;

  always_comb begin
    next_state = state;
    if (state_forced) begin
      // monitors have no say while software holds the state
      next_state = forced_state;
    end else begin
      // normal walk toward locked, also when an input is forced
      case (state)
        DPSO_ST_FREE: begin
          if (ref_ok) begin
            next_state = DPSO_ST_PRE;
          end
        end
        DPSO_ST_PRE: begin
          if (lose_ref) begin
            next_state = DPSO_ST_FREE;
          end else if (monitor.lock_ok) begin
            next_state = DPSO_ST_LOCKED;
          end
        end
        DPSO_ST_LOCKED: begin
          if (lose_ref) begin
            next_state = DPSO_ST_HOLD;
          end else if (monitor.phase_lost) begin
            next_state = DPSO_ST_PLOST;
          end
        end
        DPSO_ST_PLOST: begin
          if (lose_ref) begin
            next_state = DPSO_ST_HOLD;
          end else if (monitor.lock_ok && !monitor.phase_lost) begin
            next_state = DPSO_ST_LOCKED;
          end
        end
        DPSO_ST_HOLD: begin
          if (ref_ok) begin
            next_state = DPSO_ST_PRE2;
          end
        end
        DPSO_ST_PRE2: begin
          if (lose_ref) begin
            next_state = DPSO_ST_HOLD;
          end else if (monitor.lock_ok) begin
            next_state = DPSO_ST_LOCKED;
          end
        end
        default: begin
          next_state = DPSO_ST_FREE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      state <= DPSO_ST_FREE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pll_state_code <= DPSO_CODE_FREE;
    end else begin
      pll_state_code <= dpso_state_to_code(state);
    end
  end


  // forced input failure flag


  logic forced_fail;

  // software must see this, since the machine itself will not react
  assign forced_fail = ref_forced & ~(|(forced_hot & input_ok));

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      forced_lost <= 1'b0;
    end else if (forced_fail) begin
      // a new failure wins over a clear in the same cycle
      forced_lost <= 1'b1;
    end else if (wr_status && wr_status_bits.forced_lost) begin
      forced_lost <= 1'b0;
    end
  end


  // read side


  dpso_status_type        status;
  logic [DPSO_DATA_W-1:0] read_word;

  always_comb begin
    status              = '0;
    status.state_code   = dpso_state_to_code(state);
    status.sel_code     = dpso_hot_to_code(sel_hot);
    status.sel_valid    = sel_valid;
    status.state_forced = state_forced;
    status.ref_forced   = ref_forced;
    status.forced_lost  = forced_lost;
  end

  always_comb begin
    case (avs_address)
      DPSO_OFS_STATE_OVR: read_word = DPSO_DATA_W'(state_override_field);
      DPSO_OFS_FORCED:    read_word = DPSO_DATA_W'(forced_input_field);
      DPSO_OFS_PRIO:      read_word = DPSO_DATA_W'(input_prio);
      DPSO_OFS_STATUS:    read_word = DPSO_DATA_W'(status);
      default:            read_word = '0;
    endcase
  end

  // latched on the first request cycle, stands through the release edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_readdata <= '0;
    end else if (fetch && avs_read) begin
      avs_readdata <= read_word;
    end
  end

endmodule

// >>> verilog/dpso_pkg.sv
// constants, types and decode functions of the main pll override block
// Behaviour
// - override code 000 leaves the main pll state machine under its own control.
// - nonzero override other than 011 jumps the machine: 001 free run, 010 holdover, 100 locked.
// - override 101 is pre-locked two, 110 pre-locked, 111 phase lost; 011 unused.
// - while forced, monitors cannot move the machine; software does all monitoring.
// - forced input zero or an unknown code leaves input choice automatic; 3, 4, 5, 6 or 9 names the forced input.
// - a forced input skips all qualification and counts as valid.
// - forcing an input outside locked lets the machine walk normally toward locked.
// - a failing forced input never sends the machine into holdover.
// - forcing works by lifting the chosen input to priority 1, the highest.
package dpso_pkg;

  localparam int DPSO_NUM_IN = 5;
  localparam int DPSO_PRIO_W = 4;
  localparam int DPSO_DATA_W = 32;
  localparam int DPSO_ADDR_W = 4;
  localparam int DPSO_LANES  = DPSO_DATA_W / 8;

  // byte addresses of the register words
  localparam logic [DPSO_ADDR_W-1:0] DPSO_OFS_STATE_OVR = 4'h0;
  localparam logic [DPSO_ADDR_W-1:0] DPSO_OFS_FORCED    = 4'h4;
  localparam logic [DPSO_ADDR_W-1:0] DPSO_OFS_PRIO      = 4'h8;
  localparam logic [DPSO_ADDR_W-1:0] DPSO_OFS_STATUS    = 4'hc;

  localparam logic [2:0]  DPSO_RST_STATE_OVR = 3'h0;
  localparam logic [3:0]  DPSO_RST_FORCED    = 4'h0;
  localparam logic [19:0] DPSO_RST_PRIO      = 20'h5_4321;
  localparam logic [3:0]  DPSO_PRIO_TOP      = 4'h1;
  localparam logic [3:0]  DPSO_PRIO_OFF      = 4'h0;

  typedef enum logic [2:0] {
    DPSO_CODE_AUTO   = 3'h0,
    DPSO_CODE_FREE   = 3'h1,
    DPSO_CODE_HOLD   = 3'h2,
    DPSO_CODE_SPARE  = 3'h3,
    DPSO_CODE_LOCKED = 3'h4,
    DPSO_CODE_PRE2   = 3'h5,
    DPSO_CODE_PRE    = 3'h6,
    DPSO_CODE_PLOST  = 3'h7
  } dpso_code_type;

  // gray steps along free run, pre-locked, locked, phase lost, holdover
  typedef enum logic [2:0] {
    DPSO_ST_FREE   = 3'h0,
    DPSO_ST_PRE    = 3'h1,
    DPSO_ST_LOCKED = 3'h3,
    DPSO_ST_PLOST  = 3'h2,
    DPSO_ST_HOLD   = 3'h6,
    DPSO_ST_PRE2   = 3'h7
  } dpso_state_type;

  // forced input codes: first/second single ended, first/second differential, standby
  localparam logic [3:0] DPSO_REF_AUTO = 4'h0;
  localparam logic [3:0] DPSO_REF_CODE [DPSO_NUM_IN] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

  typedef struct packed {
    logic [20:0] spare;
    logic        forced_lost;
    logic        ref_forced;
    logic        state_forced;
    logic        sel_valid;
    logic [3:0]  sel_code;
    logic [2:0]  state_code;
  } dpso_status_type;

  typedef struct packed {
    logic lock_ok;
    logic phase_lost;
  } dpso_monitor_type;

  function automatic dpso_state_type dpso_code_to_state(input logic [2:0] code);
    case (code)
      DPSO_CODE_HOLD:   dpso_code_to_state = DPSO_ST_HOLD;
      DPSO_CODE_LOCKED: dpso_code_to_state = DPSO_ST_LOCKED;
      DPSO_CODE_PRE2:   dpso_code_to_state = DPSO_ST_PRE2;
      DPSO_CODE_PRE:    dpso_code_to_state = DPSO_ST_PRE;
      DPSO_CODE_PLOST:  dpso_code_to_state = DPSO_ST_PLOST;
      default:          dpso_code_to_state = DPSO_ST_FREE;
    endcase
  endfunction

  function automatic logic [2:0] dpso_state_to_code(input dpso_state_type st);
    case (st)
      DPSO_ST_HOLD:   dpso_state_to_code = DPSO_CODE_HOLD;
      DPSO_ST_LOCKED: dpso_state_to_code = DPSO_CODE_LOCKED;
      DPSO_ST_PRE2:   dpso_state_to_code = DPSO_CODE_PRE2;
      DPSO_ST_PRE:    dpso_state_to_code = DPSO_CODE_PRE;
      DPSO_ST_PLOST:  dpso_state_to_code = DPSO_CODE_PLOST;
      default:        dpso_state_to_code = DPSO_CODE_FREE;
    endcase
  endfunction

  function automatic logic dpso_override_on(input logic [2:0] code);
    dpso_override_on = (code != DPSO_CODE_AUTO) && (code != DPSO_CODE_SPARE);
  endfunction

  // unknown codes give an empty vector, i.e. automatic choice
  function automatic logic [DPSO_NUM_IN-1:0] dpso_ref_hot(input logic [3:0] code);
    dpso_ref_hot = '0;
    for (int i = 0; i < DPSO_NUM_IN; i++) begin
      dpso_ref_hot[i] = (code == DPSO_REF_CODE[i]);
    end
  endfunction

  function automatic logic [3:0] dpso_hot_to_code(input logic [DPSO_NUM_IN-1:0] hot);
    dpso_hot_to_code = DPSO_REF_AUTO;
    for (int i = 0; i < DPSO_NUM_IN; i++) begin
      if (hot[i]) begin
        dpso_hot_to_code = DPSO_REF_CODE[i];
      end
    end
  endfunction

  function automatic logic [DPSO_DATA_W-1:0] dpso_lane_mask(input logic [DPSO_LANES-1:0] be);
    dpso_lane_mask = '0;
    for (int b = 0; b < DPSO_LANES; b++) begin
      dpso_lane_mask[b*8 +: 8] = {8{be[b]}};
    end
  endfunction

endpackage

// >>> verilog/dpso_avs_port.sv
// avalon-mm handshake: one wait state per access
`timescale 1ns/1ps
module dpso_avs_port
  import dpso_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic avs_read,
  input  wire logic avs_write,
  output logic      avs_waitrequest,
  output logic      fetch,
  output logic      commit
);

  logic request;

  assign request = avs_read | avs_write;
  // first cycle of a request: read data gets latched
  assign fetch   = request & avs_waitrequest;
  // edge at which the master sees waitrequest low
  assign commit  = request & ~avs_waitrequest;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~fetch;
    end
  end

endmodule

// >>> verilog/dpso_ref_select.sv
// priority choice of the main pll input clock
`timescale 1ns/1ps
module dpso_ref_select
  import dpso_pkg::*;
#(
  parameter int NUM_IN = DPSO_NUM_IN,
  parameter int PRIO_W = DPSO_PRIO_W
) (
  input  wire logic [NUM_IN-1:0]        input_ok,
  input  wire logic [NUM_IN*PRIO_W-1:0] prio,
  input  wire logic [NUM_IN-1:0]        forced_hot,
  output logic      [NUM_IN-1:0]        sel_hot,
  output logic                          sel_valid
);

  logic [PRIO_W-1:0] eff_prio [NUM_IN];
  logic [NUM_IN-1:0] cand;

  for (genvar i = 0; i < NUM_IN; i++) begin : g_in
    // forced input rides the normal path at the top priority
    assign eff_prio[i] = forced_hot[i] ? PRIO_W'(DPSO_PRIO_TOP) : prio[i*PRIO_W +: PRIO_W];
    assign cand[i]     = forced_hot[i] |
                         (input_ok[i] & (eff_prio[i] != PRIO_W'(DPSO_PRIO_OFF)));
  end

  always_comb begin
    logic [PRIO_W-1:0] best;
    best      = '1;
    sel_hot   = '0;
    sel_valid = 1'b0;
    for (int i = 0; i < NUM_IN; i++) begin
      // ties go to the forced input, else to the lower index
      if (cand[i] && (!sel_valid || eff_prio[i] < best ||
          (eff_prio[i] == best && forced_hot[i]))) begin
        best      = eff_prio[i];
        sel_hot   = '0;
        sel_hot[i] = 1'b1;
        sel_valid = 1'b1;
      end
    end
  end

endmodule

// >>> dv/dpso_override_properties.sv
// concurrent checks of the main pll override block at its ports
`timescale 1ns/1ps
module dpso_override_properties
  import dpso_pkg::*;
#(
  parameter int NUM_IN = DPSO_NUM_IN,
  parameter int PRIO_W = DPSO_PRIO_W
) (
  input wire logic                   clk_sys,
  input wire logic                   arst_n,
  input wire logic [DPSO_ADDR_W-1:0] avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [DPSO_DATA_W-1:0] avs_writedata,
  input wire logic [DPSO_LANES-1:0]  avs_byteenable,
  input wire logic [DPSO_DATA_W-1:0] avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire logic [NUM_IN-1:0]      input_ok,
  input wire dpso_monitor_type       monitor,
  input wire logic [2:0]             pll_state_code,
  input wire logic [3:0]             sel_code,
  input wire logic                   sel_valid
);
  logic [2:0] ovr_q;
  logic [3:0] frc_q;
  logic       ovr_auto;
  logic       frc_ok;

  // shadow copies of the two override fields, taken at the write's accept edge
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ovr_q <= 3'h0;
    end else if (avs_write && !avs_waitrequest && avs_address == DPSO_OFS_STATE_OVR
                 && avs_byteenable[0]) begin
      ovr_q <= avs_writedata[2:0];
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      frc_q <= 4'h0;
    end else if (avs_write && !avs_waitrequest && avs_address == DPSO_OFS_FORCED
                 && avs_byteenable[0]) begin
      frc_q <= avs_writedata[3:0];
    end
  end

  assign ovr_auto = (ovr_q == 3'h0) || (ovr_q == 3'h3);
  assign frc_ok   = frc_q inside {4'h3, 4'h4, 4'h5, 4'h6, 4'h9};

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  sequence s_ovr_wr;
    avs_write && !avs_waitrequest && avs_address == DPSO_OFS_STATE_OVR && avs_byteenable[0]
      && avs_writedata[2:0] != 3'h0 && avs_writedata[2:0] != 3'h3;
  endsequence

  sequence s_ovr_steady;
    !ovr_auto && $stable(ovr_q);
  endsequence

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered after one wait state");
  a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  a_read_back: assert property (avs_read && !avs_waitrequest
      && avs_address == DPSO_OFS_STATE_OVR |-> avs_readdata == {29'h0, ovr_q})
    else $error("state override read back wrong");
  a_ovr_write: assert property (s_ovr_wr
      |-> ##3 pll_state_code == $past(avs_writedata[2:0], 3))
    else $error("forced state code not reached");
  a_code_unused: assert property (pll_state_code != 3'h3)
    else $error("unused state code shown");
  a_force_steady: assert property (s_ovr_steady [*4] |-> $stable(pll_state_code))
    else $error("forced state moved");
  a_frc_sel: assert property (frc_ok && $past(frc_ok)
      |-> sel_code == $past(frc_q) && sel_valid)
    else $error("forced input not selected");
  a_auto_empty: assert property (!frc_ok && $past(!frc_ok) && $past(input_ok) == '0
      |-> !sel_valid && sel_code == 4'h0)
    else $error("input selected with no good input");
  a_no_hold: assert property (ovr_auto && $past(ovr_auto) && $past(ovr_auto, 2) && frc_ok
      && $past(frc_ok) && $past(frc_ok, 2) && pll_state_code != 3'h2
      |=> pll_state_code != 3'h2)
    else $error("holdover entered with a forced input");
  a_walk_lock: assert property (frc_ok && $past(frc_ok) && ovr_auto && $past(ovr_auto)
      && pll_state_code == 3'h1 |-> ##[1:4] pll_state_code == 3'h6)
    else $error("free run did not step toward lock");
endmodule

bind dpso_override dpso_override_properties #(
  .NUM_IN(NUM_IN),
  .PRIO_W(PRIO_W)
) u_props (
  .clk_sys        (clk_sys),
  .arst_n         (arst_n),
  .avs_address    (avs_address),
  .avs_read       (avs_read),
  .avs_write      (avs_write),
  .avs_writedata  (avs_writedata),
  .avs_byteenable (avs_byteenable),
  .avs_readdata   (avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .input_ok       (input_ok),
  .monitor        (monitor),
  .pll_state_code (pll_state_code),
  .sel_code       (sel_code),
  .sel_valid      (sel_valid)
);

// >>> dv/dpso_override_tb.sv
// self-checking bench for the main pll override block
`timescale 1ns/1ps
module dpso_override_tb;
  import dpso_pkg::*;

  logic                   clk_sys = 1'b0;
  logic                   arst_n = 1'b0;
  logic [DPSO_ADDR_W-1:0] avs_address = '0;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [DPSO_DATA_W-1:0] avs_writedata = '0;
  logic [DPSO_LANES-1:0]  avs_byteenable = '0;
  logic [DPSO_DATA_W-1:0] avs_readdata;
  logic                   avs_waitrequest;
  logic [DPSO_NUM_IN-1:0] input_ok = '0;
  dpso_monitor_type       monitor = '0;
  logic [2:0]             pll_state_code;
  logic [3:0]             sel_code;
  logic                   sel_valid;
  logic [DPSO_DATA_W-1:0] rdata;
  dpso_status_type        stat;
  int                     bad_count = 0;
  int                     n_compared = 0;
  logic [2:0]             ovr_codes [6] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};

  always #25 clk_sys = ~clk_sys;

  dpso_override u_dut (
    .clk_sys        (clk_sys),
    .arst_n         (arst_n),
    .avs_address    (avs_address),
    .avs_read       (avs_read),
    .avs_write      (avs_write),
    .avs_writedata  (avs_writedata),
    .avs_byteenable (avs_byteenable),
    .avs_readdata   (avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .input_ok       (input_ok),
    .monitor        (monitor),
    .pll_state_code (pll_state_code),
    .sel_code       (sel_code),
    .sel_valid      (sel_valid)
  );

  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_out(input logic [2:0] st, input logic [3:0] sel, input logic vld);
    check({24'h0, pll_state_code, sel_code, sel_valid}, {24'h0, st, sel, vld});
  endtask

  // request is held until waitrequest is sampled low; no latency is assumed
  task automatic bus_write(input logic [3:0] adr, input logic [31:0] dat, input logic [3:0] be);
    @(posedge clk_sys);
    avs_address    <= adr;
    avs_writedata  <= dat;
    avs_byteenable <= be;
    avs_write      <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    avs_write <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] adr);
    @(posedge clk_sys);
    avs_address <= adr;
    avs_read    <= 1'b1;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rdata = avs_readdata;
    avs_read <= 1'b0;
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  initial begin
    repeat (4000) @(posedge clk_sys);
    bad_count++;
    $display("mismatch at %0t: watchdog expired", $time);
    stop_test();
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    check_out(3'h1, 4'h0, 1'b0);
    bus_read(DPSO_OFS_STATE_OVR);
    check(rdata, 32'h0000_0000);
    bus_read(DPSO_OFS_FORCED);
    check(rdata, 32'h0000_0000);
    bus_read(DPSO_OFS_PRIO);
    check(rdata, {12'h000, DPSO_RST_PRIO});
    // only lane 0 may change
    bus_write(DPSO_OFS_PRIO, 32'hffff_ff77, 4'h1);
    bus_read(DPSO_OFS_PRIO);
    check(rdata, 32'h0005_4377);
    bus_write(DPSO_OFS_PRIO, 32'h0005_4321, 4'hf);
    // unmapped slot: write dropped, reads zero
    bus_write(4'h2, 32'h0000_0007, 4'hf);
    bus_read(4'h2);
    check(rdata, 32'h0000_0000);
    bus_read(DPSO_OFS_STATE_OVR);
    check(rdata, 32'h0000_0000);

    // force a dead input from free run: selected, walks to lock, no holdover
    bus_write(DPSO_OFS_FORCED, 32'h0000_0005, 4'h1);
    wait_cyc(5);
    check_out(3'h6, 4'h5, 1'b1);
    monitor <= '{lock_ok: 1'b1, phase_lost: 1'b0};
    wait_cyc(10);
    check_out(3'h4, 4'h5, 1'b1);
    bus_read(DPSO_OFS_STATUS);
    stat = '0;
    stat.state_code  = 3'h4;
    stat.sel_code    = 4'h5;
    stat.sel_valid   = 1'b1;
    stat.ref_forced  = 1'b1;
    stat.forced_lost = 1'b1;
    check(rdata, stat);
    for (int i = 0; i < DPSO_NUM_IN; i++) begin
      bus_write(DPSO_OFS_FORCED, {28'h0, DPSO_REF_CODE[i]}, 4'h1);
      wait_cyc(3);
      check_out(3'h4, DPSO_REF_CODE[i], 1'b1);
    end

    // unused input code behaves as automatic: dead inputs, so holdover
    bus_write(DPSO_OFS_FORCED, 32'h0000_0001, 4'h1);
    wait_cyc(5);
    check_out(3'h2, 4'h0, 1'b0);
    bus_write(DPSO_OFS_STATUS, 32'h0000_0400, 4'h3);
    bus_read(DPSO_OFS_STATUS);
    stat = '0;
    stat.state_code = 3'h2;
    check(rdata, stat);
    input_ok <= 5'b00001;
    bus_write(DPSO_OFS_FORCED, 32'h0000_0000, 4'h1);
    wait_cyc(6);
    check_out(3'h4, 4'h3, 1'b1);
    // forced input ties with a good priority 1 input and must win
    input_ok <= 5'b00011;
    bus_write(DPSO_OFS_FORCED, 32'h0000_0004, 4'h1);
    wait_cyc(3);
    check_out(3'h4, 4'h4, 1'b1);
    bus_write(DPSO_OFS_FORCED, 32'h0000_0000, 4'h1);

    // forced states must ignore monitors that would move the machine
    input_ok <= '0;
    monitor  <= '{lock_ok: 1'b0, phase_lost: 1'b1};
    for (int i = 0; i < 6; i++) begin
      bus_write(DPSO_OFS_STATE_OVR, {29'h0, ovr_codes[i]}, 4'h1);
      wait_cyc(6);
      check_out(ovr_codes[i], 4'h0, 1'b0);
      bus_read(DPSO_OFS_STATUS);
      check(rdata, {23'h0, 1'b1, 5'h00, ovr_codes[i]});
    end
    bus_write(DPSO_OFS_STATE_OVR, 32'h0000_0003, 4'h1);
    wait_cyc(6);
    check_out(3'h2, 4'h0, 1'b0);
    input_ok <= 5'b00001;
    monitor  <= '{lock_ok: 1'b1, phase_lost: 1'b0};
    bus_write(DPSO_OFS_STATE_OVR, 32'h0000_0000, 4'h1);
    wait_cyc(6);
    check_out(3'h4, 4'h3, 1'b1);

    monitor <= '{lock_ok: 1'b0, phase_lost: 1'b1};
    wait_cyc(4);
    check_out(3'h7, 4'h3, 1'b1);

    // second reset in mid-run
    arst_n <= 1'b0;
    input_ok <= '0;
    wait_cyc(2);
    arst_n <= 1'b1;
    check_out(3'h1, 4'h0, 1'b0);
    bus_read(DPSO_OFS_FORCED);
    check(rdata, 32'h0000_0000);
    stop_test();
  end
endmodule
